/* verilog/sfd_top.sv */
// Supply fault detector channel: registers, primary and lent detector.
// Assumes an SMBus slave front end delivers decoded byte reads and writes.
module sfd_top
  import sfd_pkg::*;
// How it works
// - Each detector keeps its own 8-bit over and under thresholds compared directly to the code.
// - While over is flagged the over threshold drops by its 5-bit hysteresis.
// - While under is flagged the under threshold rises by its 5-bit hysteresis.
// - A glitch filter of 0 to 100 us, picked by bits 4:2, delays every fault change.
// - Bits 1:0 of the config select over, window, under or off.
// - Bits 1:0 of the range register pick mid, low or ultralow range.
// - The dual-function input is either an analog detector or a logic input.
// - In logic mode the pin is synchronised and shown as a level.
// - In logic mode its detector watches the partner dedicated input instead.
// - The lent detector then serves as an alarm beside the primary fault, with own settings.
// - All registers are read and written through the SMBus register port.
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] dedicated_supply_input_a,
  input  wire logic [7:0] dual_function_input_a,
  input  wire logic       dual_function_level_a,
  output logic      [1:0] primary_range,
  output logic      [1:0] aux_range,
  output logic            logic_mode,
  output logic            logic_level,
  output logic            fault_out,
  output logic            alarm_out
);
  logic [7:0] regs_r [SFD_NDET][SFD_NREG];
  logic [7:0] mode_r;
  logic [7:0] rdata_r;
  logic [7:0] prim_s1_r;
  logic [7:0] prim_s2_r;
  logic [7:0] dual_s1_r;
  logic [7:0] dual_s2_r;
  logic       lvl_s1_r;
  logic       lvl_s2_r;
  logic       lvl_r;
  logic [1:0] prng_r;
  logic [1:0] arng_r;
  logic       flt_r;
  logic       alm_r;
  logic [7:0] mask   [SFD_NREG];
  logic [7:0] rsel   [SFD_NDET];
  logic       hit    [SFD_NDET];
  logic [2:0] idx    [SFD_NDET];
  logic       fault  [SFD_NDET];
  logic       mode_hit;
  logic       is_logic;
  logic [7:0] rd_nxt;

  assign mask[0] = SFD_MSK_TH;
  assign mask[1] = SFD_MSK_HY;
  assign mask[2] = SFD_MSK_TH;
  assign mask[3] = SFD_MSK_HY;
  assign mask[4] = SFD_MSK_CFG;
  assign mask[5] = SFD_MSK_SEL;
  assign mode_hit = (reg_addr == SFD_OFS_MODE);
  assign is_logic = mode_r[0];

  // Two-flop synchronisers for the front-end codes and the logic pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prim_s1_r <= SFD_RST_ZERO;
      prim_s2_r <= SFD_RST_ZERO;
      dual_s1_r <= SFD_RST_ZERO;
      dual_s2_r <= SFD_RST_ZERO;
      lvl_s1_r  <= 1'b0;
      lvl_s2_r  <= 1'b0;
    end else if (clk_en) begin
      prim_s1_r <= dedicated_supply_input_a;
      prim_s2_r <= prim_s1_r;
      dual_s1_r <= dual_function_input_a;
      dual_s2_r <= dual_s1_r;
      lvl_s1_r  <= dual_function_level_a;
      lvl_s2_r  <= lvl_s1_r;
    end
  end

  // Per-detector register bank, decode and detector instance
  genvar d;
  generate
    for (d = 0; d < SFD_NDET; d++) begin : g_det
      logic [7:0] base;
      logic [7:0] off;
      sfd_det_if  dif ();

      assign base   = (d == 0) ? SFD_OFS_OV_TH : SFD_OFS_AUX;
      assign off    = reg_addr - base;
      assign hit[d] = (reg_addr >= base) && (off < 8'(SFD_NREG));
      assign idx[d] = off[2:0];
      assign rsel[d] = hit[d] ? regs_r[d][idx[d]] : SFD_RST_ZERO;

      // Config fields feed the detector directly
      assign dif.ov_th  = regs_r[d][0];
      assign dif.ov_hy  = regs_r[d][1][SFD_HY_HI:0];
      assign dif.uv_th  = regs_r[d][2];
      assign dif.uv_hy  = regs_r[d][3][SFD_HY_HI:0];
      assign dif.gf_sel = regs_r[d][4][SFD_GF_HI:SFD_GF_LO];
      assign dif.kind   = sfd_kind_t'(regs_r[d][4][SFD_FLT_HI:0]);
      // Lent detector watches the partner input in logic mode
      assign dif.code   = (d == 0) ? prim_s2_r :
                          (is_logic ? prim_s2_r : dual_s2_r);
      assign fault[d]   = dif.fault;

      sfd_det u_det (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .dif     (dif)
      );

      // Register writes keep only usable bits
      for (genvar r = 0; r < SFD_NREG; r++) begin : g_reg
        always_ff @(posedge sys_clk or negedge nrst) begin
          if (!nrst) begin
            regs_r[d][r] <= (r == 4) ? SFD_RST_CFG : SFD_RST_ZERO;
          end else if (clk_en && reg_wr && hit[d] && idx[d] == 3'(r)) begin
            regs_r[d][r] <= reg_wdata & mask[r];
          end
        end
      end
    end
  endgenerate

  // Mode register for the dual-function input
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= SFD_RST_ZERO;
    end else if (clk_en && reg_wr && mode_hit) begin
      mode_r <= reg_wdata & SFD_MSK_MODE;
    end
  end

  // Read mux; unmapped addresses return zero
  assign rd_nxt = hit[0] ? rsel[0] :
                  hit[1] ? rsel[1] :
                  mode_hit ? mode_r : SFD_RST_ZERO;

  // Registered outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= SFD_RST_ZERO;
      lvl_r   <= 1'b0;
      prng_r  <= SFD_RNG_MID;
      arng_r  <= SFD_RNG_MID;
      flt_r   <= 1'b0;
      alm_r   <= 1'b0;
    end else if (clk_en) begin
      if (reg_rd) begin
        rdata_r <= rd_nxt;
      end
      lvl_r  <= is_logic & lvl_s2_r;
      prng_r <= regs_r[0][5][SFD_SEL_HI] ? SFD_RNG_ULOW : regs_r[0][5][1:0];
      arng_r <= regs_r[1][5][SFD_SEL_HI] ? SFD_RNG_ULOW : regs_r[1][5][1:0];
      flt_r  <= fault[0];
      alm_r  <= fault[1];
    end
  end

  assign reg_rdata     = rdata_r;
  assign primary_range = prng_r;
  assign aux_range     = arng_r;
  assign logic_mode    = mode_r[0];
  assign logic_level   = lvl_r;
  assign fault_out     = flt_r;
  assign alarm_out     = alm_r;
endmodule : sfd_top

/* verilog/sfd_pkg.sv */
// Shared constants for the supply fault detector channel.
// Assumes a 20 MHz system clock and a byte-wide register port.
package sfd_pkg;
  // Register offsets of the channel's primary detector
  localparam logic [7:0] SFD_OFS_OV_TH  = 8'h08;
  localparam logic [7:0] SFD_OFS_OV_HY  = 8'h09;
  localparam logic [7:0] SFD_OFS_UV_TH  = 8'h0a;
  localparam logic [7:0] SFD_OFS_UV_HY  = 8'h0b;
  localparam logic [7:0] SFD_OFS_CFG    = 8'h0c;
  localparam logic [7:0] SFD_OFS_SEL    = 8'h0d;
  // Lent detector bank and dual-function mode register
  localparam logic [7:0] SFD_OFS_AUX    = 8'h30;
  localparam logic [7:0] SFD_OFS_MODE   = 8'h36;
  localparam int         SFD_NREG       = 6;
  localparam int         SFD_NDET       = 2;

  // Writable masks; other bits read as zero
  localparam logic [7:0] SFD_MSK_TH     = 8'hff;
  localparam logic [7:0] SFD_MSK_HY     = 8'h1f;
  localparam logic [7:0] SFD_MSK_CFG    = 8'h1f;
  localparam logic [7:0] SFD_MSK_SEL    = 8'h03;
  localparam logic [7:0] SFD_MSK_MODE   = 8'h01;

  // Field positions
  localparam int SFD_HY_HI   = 4;
  localparam int SFD_GF_HI   = 4;
  localparam int SFD_GF_LO   = 2;
  localparam int SFD_FLT_HI  = 1;
  localparam int SFD_SEL_HI  = 1;

  // Reset values: detector off until configured
  localparam logic [7:0] SFD_RST_ZERO   = 8'h00;
  localparam logic [7:0] SFD_RST_CFG    = 8'h03;

  typedef enum logic [1:0] {
    SFD_FLT_OV  = 2'b00,
    SFD_FLT_WIN = 2'b01,
    SFD_FLT_UV  = 2'b10,
    SFD_FLT_OFF = 2'b11
  } sfd_kind_t;

  typedef enum logic [1:0] {
    SFD_RNG_MID  = 2'b00,
    SFD_RNG_LOW  = 2'b01,
    SFD_RNG_ULOW = 2'b10
  } sfd_range_t;

  // Glitch filter delays in microseconds and cycles at 20 MHz
  localparam int SFD_CLK_KHZ = 20000;
  localparam int SFD_CNT_W   = 12;
  localparam int SFD_GF_US [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
  function automatic logic [SFD_CNT_W-1:0] sfd_gf_cycles(input logic [2:0] sel);
    sfd_gf_cycles = SFD_CNT_W'((SFD_GF_US[sel] * SFD_CLK_KHZ) / 1000);
  endfunction : sfd_gf_cycles
endpackage : sfd_pkg

/* verilog/sfd_det_if.sv */
// Carrier between the register file and one detector.
// Assumes both ends run on the same clock.
interface sfd_det_if;
  import sfd_pkg::*;
  logic [7:0] ov_th;
  logic [4:0] ov_hy;
  logic [7:0] uv_th;
  logic [4:0] uv_hy;
  logic [2:0] gf_sel;
  sfd_kind_t  kind;
  logic [7:0] code;
  logic       fault;
  modport ctrl (output ov_th, ov_hy, uv_th, uv_hy, gf_sel, kind, code, input fault);
  modport det  (input ov_th, ov_hy, uv_th, uv_hy, gf_sel, kind, code, output fault);
endinterface : sfd_det_if

/* verilog/sfd_det.sv */
// One threshold detector with hysteresis, fault kind select and glitch filter.
// Assumes its sample code is already synchronised to sys_clk.
module sfd_det
  import sfd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  sfd_det_if.det   dif
);
  logic                 ov_r;
  logic                 uv_r;
  logic                 flt_r;
  logic [SFD_CNT_W-1:0] cnt_r;
  logic [8:0]           ov_eff;
  logic [8:0]           uv_eff;
  logic                 ov_nxt;
  logic                 uv_nxt;
  logic                 raw;
  logic [SFD_CNT_W-1:0] limit;

  // Effective thresholds, 9 bits wide; an over threshold below zero keeps over set
  assign ov_eff = ov_r ? ({1'b0, dif.ov_th} - {4'h0, dif.ov_hy}) : {1'b0, dif.ov_th};
  assign uv_eff = uv_r ? ({1'b0, dif.uv_th} + {4'h0, dif.uv_hy}) : {1'b0, dif.uv_th};
  assign ov_nxt = ov_eff[8] ? 1'b1 : ({1'b0, dif.code} > ov_eff);
  assign uv_nxt = ({1'b0, dif.code} < uv_eff);

  // Fault kind selection
  assign raw = (dif.kind == SFD_FLT_OV)  ? ov_r :
               (dif.kind == SFD_FLT_WIN) ? (ov_r | uv_r) :
               (dif.kind == SFD_FLT_UV)  ? uv_r : 1'b0;
  assign limit = sfd_gf_cycles(dif.gf_sel);
  assign dif.fault = flt_r;

  // Comparator state holds the hysteresis
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ov_r <= 1'b0;
      uv_r <= 1'b0;
    end else if (clk_en) begin
      ov_r <= ov_nxt;
      uv_r <= uv_nxt;
    end
  end

  // Output follows raw only after it held for the selected delay
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      flt_r <= 1'b0;
    end else if (clk_en) begin
      if (raw == flt_r) begin
        cnt_r <= '0;
      end else if (cnt_r >= limit) begin
        flt_r <= raw;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : sfd_det

/* bench/sfd_chk.sv */
// Port checker for the supply fault detector channel.
// Assumes a bind onto sfd_top; one clock, async low reset.
module sfd_chk
  import sfd_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] primary_range,
  input wire logic [1:0] aux_range,
  input wire logic       logic_mode,
  input wire logic       logic_level,
  input wire logic       fault_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Strobes the port really takes
  wire rd_tk = reg_rd && clk_en;
  wire wr_tk = reg_wr && clk_en;
  // Read port, reserved bits and unmapped space
  property p_rd_hold; !rd_tk |=> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_unm; rd_tk && reg_addr == 8'hff |=> reg_rdata == 8'h00; endproperty
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  property p_rd_hy; rd_tk && reg_addr == SFD_OFS_OV_HY |=> reg_rdata[7:5] == 3'h0; endproperty
  a_rd_hy: assert property (p_rd_hy) else $error("hysteresis high bits set");
  // Range outputs
  property p_rng_ok; primary_range != 2'h3 && aux_range != 2'h3; endproperty
  a_rng_ok: assert property (p_rng_ok) else $error("range code 11 shown");
  property p_rng_wr; wr_tk && reg_addr == SFD_OFS_SEL && reg_wdata[1] |-> ##[1:3] primary_range == 2'h2; endproperty
  a_rng_wr: assert property (p_rng_wr) else $error("ultralow not selected");
  // Dual pin mode and level
  property p_mode; wr_tk && reg_addr == SFD_OFS_MODE && reg_wdata[0] |-> ##[1:3] logic_mode; endproperty
  a_mode: assert property (p_mode) else $error("logic mode not set");
  property p_lvl; !logic_mode && !$past(logic_mode) |-> !logic_level; endproperty
  a_lvl: assert property (p_lvl) else $error("level shown in analog mode");
  // Detector switched off with no filter delay
  property p_off; wr_tk && reg_addr == SFD_OFS_CFG && reg_wdata[4:0] == 5'h03 |-> ##[1:8] !fault_out; endproperty
  a_off: assert property (p_off) else $error("fault stays when off");
  c_flt: cover property ($rose(fault_out));
  c_lvl: cover property ($rose(logic_level));
  c_rng: cover property (primary_range == 2'h2);
endmodule : sfd_chk
bind sfd_top sfd_chk sfd_chk_i (.*);

/* bench/sfd_rail.sv */
// Model of the supervised rails and the dual pin level.
// Assumes targets are set at the falling clock edge.
module sfd_rail (
  input  wire logic [7:0] set_a,
  input  wire logic [7:0] set_x,
  input  wire logic       set_l,
  output logic      [7:0] rail_a,
  output logic      [7:0] rail_x,
  output logic            pin_l
);
  timeunit 1ns;
  timeprecision 1ns;
  // Rails settle out of step with the clock
  assign #13 rail_a = set_a;
  assign #17 rail_x = set_x;
  assign #9 pin_l = set_l;
endmodule : sfd_rail

/* bench/sfd_top_bench.sv */
// Self-checking bench for the supply fault detector channel.
// Assumes the bound checker and the rail model beside sfd_top.
module sfd_top_bench
  import sfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, nrst, clk_en, reg_wr, reg_rd, set_l, sreq, rp, rpp, sp;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, set_a, set_x, a, d;
  logic [7:0] dedicated_supply_input_a, dual_function_input_a;
  logic       dual_function_level_a, logic_mode, logic_level, fault_out, alarm_out;
  logic [1:0] primary_range, aux_range;
  logic [7:0] q[$];
  int         err_total = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         us[8] = '{0, 5, 10, 20, 30, 50, 75, 100};
  logic [7:0] ofs[6] = '{SFD_OFS_OV_TH, SFD_OFS_OV_HY, SFD_OFS_UV_TH, SFD_OFS_UV_HY,
                         SFD_OFS_CFG, SFD_OFS_SEL};
  logic [7:0] msk[6] = '{SFD_MSK_TH, SFD_MSK_HY, SFD_MSK_TH, SFD_MSK_HY, SFD_MSK_CFG,
                         SFD_MSK_SEL};
  logic [7:0] tcfg[10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01, 8'h03};
  logic [7:0] tcod[10] = '{8'h81, 8'h75, 8'h70, 8'h3f, 8'h45, 8'h48, 8'h90, 8'h60, 8'h30, 8'h90};
  logic [9:0] texp = 10'h15b;
  wire  [7:0] outs = {alarm_out, fault_out, logic_level, logic_mode, aux_range, primary_range};
  sfd_top sfd_top_i (.*);
  sfd_rail sfd_rail_i (.set_a(set_a), .set_x(set_x), .set_l(set_l),
    .rail_a(dedicated_supply_input_a), .rail_x(dual_function_input_a),
    .pin_l(dual_function_level_a));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic rst;
    nrst = 1'b0;
    tick(5);
    nrst = 1'b1;
    clk_en = 1'b1;
    tick(1);
  endtask : rst
  task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
    reg_addr = ad;
    reg_wdata = dd;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  // Note the expected byte, then strobe a read
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    q.push_back(e);
    reg_addr = ad;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(2);
  endtask : rd
  // Note the expected output byte, then ask for a sample
  task automatic obs(input logic [7:0] e);
    q.push_back(e);
    sreq = 1'b1;
    tick(1);
    sreq = 1'b0;
    tick(1);
  endtask : obs
  function automatic logic [1:0] rng(input int s);
    return s > 1 ? 2'h2 : 2'(s);
  endfunction : rng
  // Pipeline of taken requests and the hang limit
  always @(posedge sys_clk) begin
    rp <= reg_rd & clk_en;
    rpp <= rp;
    sp <= sreq;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end
  // Results are compared against the oldest note
  always @(negedge sys_clk) begin
    if (rpp) check(reg_rdata, q.pop_front());
    if (sp) check(outs, q.pop_front());
  end
  initial begin
    void'($urandom(32'h6073bad4));
    {nrst, clk_en, reg_wr, reg_rd, sreq, rp, rpp, sp, set_l} = '0;
    {reg_addr, reg_wdata} = '0;
    set_a = 8'h10;
    set_x = 8'h10;
    rst();
    // Reset values and masked random writes in both banks
    foreach (ofs[i]) begin
      for (int b = 0; b < 2; b++) begin
        a = ofs[i] + (b ? 8'h28 : 8'h00);
        d = 8'($urandom);
        rd(a, ofs[i] == SFD_OFS_CFG ? SFD_RST_CFG : 8'h00);
        wr(a, d);
        rd(a, d & msk[i]);
      end
    end
    wr(8'hff, d);
    rd(8'hff, 8'h00);
    wr(SFD_OFS_MODE, d);
    rd(SFD_OFS_MODE, d & SFD_MSK_MODE);
    // Mid-run reset, then a write with the enable low
    rst();
    clk_en = 1'b0;
    wr(SFD_OFS_OV_TH, 8'h55);
    clk_en = 1'b1;
    rd(SFD_OFS_OV_TH, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(SFD_OFS_SEL, 8'(s));
      wr(SFD_OFS_AUX + 8'h05, 8'(3 - s));
      tick(3);
      obs({4'h0, rng(3 - s), rng(s)});
    end
    // Fault kinds with hysteresis on both thresholds
    wr(SFD_OFS_OV_TH, 8'h80);
    wr(SFD_OFS_OV_HY, 8'h10);
    wr(SFD_OFS_UV_TH, 8'h40);
    wr(SFD_OFS_UV_HY, 8'h08);
    foreach (tcfg[i]) begin
      wr(SFD_OFS_CFG, tcfg[i]);
      set_a = tcod[i];
      tick(10);
      obs({1'b0, texp[i], 6'h02});
    end
    // Every glitch filter delay, on rise and on release
    for (int g = 0; g < 8; g++) begin
      set_a = 8'h10;
      wr(SFD_OFS_CFG, 8'(g << 2));
      set_a = 8'h90;
      if (g > 0) begin
        tick(us[g] * 20 - 4);
        obs(8'h02);
      end
      tick(12);
      obs(8'h42);
      set_a = 8'h10;
      tick(us[g] * 20 + 12);
      obs(8'h02);
    end
    // Dual input as detector, then as logic input lending it
    wr(SFD_OFS_CFG, 8'h03);
    wr(SFD_OFS_AUX, 8'h50);
    wr(SFD_OFS_AUX + 8'h04, 8'h00);
    set_x = 8'h60;
    tick(10);
    obs(8'h82);
    wr(SFD_OFS_MODE, 8'h01);
    tick(10);
    obs(8'h12);
    set_a = 8'h60;
    set_l = 1'b1;
    tick(10);
    obs(8'hb2);
    end_sim();
  end
endmodule : sfd_top_bench
